/* common/scaling_io_pkg.sv */
package scaling_io_pkg;

  // Parameter addresses as seen by the fieldbus
  localparam logic [15:0] ADDR_SCALE_USER_UNITS = 16'h060e;
  localparam logic [15:0] ADDR_SCALE_REVOLUTIONS = 16'h0610;
  localparam logic [15:0] ADDR_LINE_FUNC_BASE = 16'h0722;
  localparam logic [15:0] ADDR_LINE_FUNC_STEP = 16'h0002;
  localparam logic [15:0] ADDR_LINE_LEVELS = 16'h0730;
  localparam logic [15:0] ADDR_FREE_OUTPUTS = 16'h0732;

  localparam int LINE_COUNT = 4;

  // Factory values
  localparam logic [31:0] RESET_SCALE_REVOLUTIONS = 32'h0000_0001;
  localparam logic [31:0] RESET_SCALE_USER_UNITS = 32'h0000_4000;
  localparam logic [3:0] RESET_FREE_OUTPUTS = 4'h0;

  // Internal increments per revolution, as a shift
  localparam int INC_PER_REV_SHIFT = 15;

  // Divider geometry
  localparam int DIVIDEND_W = 80;
  localparam int DIVISOR_W = 48;
  localparam logic [6:0] DIV_STEPS = 7'h50;
  localparam logic [79:0] POS_MAX_MAG = 80'h0000_0000_0000_7fff_ffff;
  localparam logic [79:0] NEG_MAX_MAG = 80'h0000_0000_0000_8000_0000;

  // Line function codes
  localparam logic [15:0] FN_IN_FREE = 16'h0001;
  localparam logic [15:0] FN_IN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_IN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_IN_HALT = 16'h0004;
  localparam logic [15:0] FN_IN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_IN_JOG_NEG = 16'h000a;
  localparam logic [15:0] FN_IN_JOG_FAST = 16'h000b;
  localparam logic [15:0] FN_IN_REF_SWITCH = 16'h0014;
  localparam logic [15:0] FN_IN_LIMIT_POS = 16'h0015;
  localparam logic [15:0] FN_IN_LIMIT_NEG = 16'h0016;
  localparam logic [15:0] FN_OUT_FREE = 16'h0065;
  localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
  localparam logic [15:0] FN_OUT_ACTIVE = 16'h0067;

  localparam logic [63:0] RESET_LINE_FUNCS =
    {FN_IN_REF_SWITCH, FN_IN_FREE, FN_IN_LIMIT_NEG, FN_IN_LIMIT_POS};

  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_FINISH} conv_state_t;

  typedef struct packed {
    logic fault_reset;
    logic enable;
    logic halt;
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
    logic ref_switch;
    logic limit_switch_positive;
    logic limit_switch_negative;
  } in_funcs_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } param_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } param_rsp_t;

endpackage

/* design/position_scaling_io_assign.sv */
`timescale 1ns/1ps
module position_scaling_io_assign
  import scaling_io_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_stage_enabled,
  input wire logic no_fault,
  input wire logic drive_active,
  input wire param_req_t param_in,
  output param_rsp_t param_out,
  input wire logic conv_req,
  input wire logic conv_to_user,
  input wire logic [31:0] conv_value,
  output logic conv_busy,
  output logic conv_done,
  output logic [31:0] conv_result,
  output logic conv_limited,
  output logic scale_fine,
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  output logic [3:0] line_oe_n,
  output in_funcs_t input_functions
);

  typedef struct packed {
    logic [31:0] scale_revolutions;
    logic [31:0] scale_user_units;
    logic [31:0] act_num;
    logic [31:0] act_den;
    logic fine;
    logic [3:0][15:0] func;
    logic [3:0] free_out;
    param_rsp_t rsp;
    conv_state_t cst;
    logic [6:0] cnt;
    logic [79:0] quo;
    logic [47:0] rem;
    logic [47:0] dvs;
    logic neg;
    logic busy;
    logic done;
    logic limited;
    logic [31:0] result;
    logic [3:0] line_out;
    logic [3:0] line_oe_n;
    in_funcs_t funcs;
  } state_t;

  logic rst_meta;
  logic rst_n;
  state_t st;
  state_t next_st;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Legal code for a given line; limit switches are tied to lines one and two
  function automatic logic code_ok(input logic [1:0] line,
                                   input logic [15:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      FN_IN_FREE, FN_IN_FAULT_RESET, FN_IN_ENABLE, FN_IN_HALT,
      FN_IN_JOG_POS, FN_IN_JOG_NEG, FN_IN_JOG_FAST, FN_IN_REF_SWITCH,
      FN_OUT_FREE, FN_OUT_NO_FAULT, FN_OUT_ACTIVE: ok = 1'b1;
      FN_IN_LIMIT_POS: ok = (line == 2'd0);
      FN_IN_LIMIT_NEG: ok = (line == 2'd1);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Per-line decode of the assigned function
  in_funcs_t line_hit [LINE_COUNT];
  logic [3:0] line_drives;
  logic [3:0] line_value;
  logic [3:0] line_free_in;

  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_line
      logic [15:0] fn;
      logic lvl;
      assign fn = st.func[gi];
      assign lvl = line_in[gi];
      assign line_hit[gi].fault_reset = lvl && fn == FN_IN_FAULT_RESET;
      assign line_hit[gi].enable = lvl && fn == FN_IN_ENABLE;
      assign line_hit[gi].halt = lvl && fn == FN_IN_HALT;
      assign line_hit[gi].jog_pos = lvl && fn == FN_IN_JOG_POS;
      assign line_hit[gi].jog_neg = lvl && fn == FN_IN_JOG_NEG;
      assign line_hit[gi].jog_fast = lvl && fn == FN_IN_JOG_FAST;
      assign line_hit[gi].ref_switch = lvl && fn == FN_IN_REF_SWITCH;
      assign line_hit[gi].limit_switch_positive =
        lvl && fn == FN_IN_LIMIT_POS;
      assign line_hit[gi].limit_switch_negative =
        lvl && fn == FN_IN_LIMIT_NEG;
      assign line_drives[gi] = fn >= FN_OUT_FREE;
      assign line_value[gi] = (fn == FN_OUT_FREE) ? st.free_out[gi] :
                              (fn == FN_OUT_NO_FAULT) ? no_fault :
                              (fn == FN_OUT_ACTIVE) ? drive_active : 1'b0;
      assign line_free_in[gi] = lvl && fn == FN_IN_FREE;
    end
  endgenerate

  logic [32:0] mag_in;
  logic [48:0] trial;
  logic [79:0] lim_mag;
  logic [79:0] out_mag;
  logic [1:0] line_sel;
  logic [15:0] addr_off;
  logic wr_ok;

  always_comb begin
    next_st = st;
    mag_in = '0;
    trial = '0;
    lim_mag = '0;
    out_mag = '0;
    line_sel = '0;
    addr_off = '0;
    wr_ok = 1'b0;

    next_st.rsp = '0;
    next_st.done = 1'b0;

    // Parameter access: answer one cycle after the request
    if (param_in.req) begin
      next_st.rsp.ack = 1'b1;
      addr_off = param_in.addr - ADDR_LINE_FUNC_BASE;
      line_sel = addr_off[2:1];
      // Signed range check shared by both scale parameters
      wr_ok = !power_stage_enabled && !param_in.wdata[31] &&
              param_in.wdata != '0;
      if (param_in.addr == ADDR_SCALE_REVOLUTIONS) begin
        next_st.rsp.rdata = st.scale_revolutions;
        if (param_in.we) begin
          if (wr_ok) begin
            next_st.scale_revolutions = param_in.wdata;
            next_st.act_num = param_in.wdata;
            next_st.act_den = st.scale_user_units;
            // Finer than one revolution per 32768 user units
            next_st.fine = {1'b0, st.scale_user_units} >
                           ({16'h0000, param_in.wdata} <<
                            INC_PER_REV_SHIFT);
          end else begin
            next_st.rsp.err = 1'b1;
          end
        end
      end else if (param_in.addr == ADDR_SCALE_USER_UNITS) begin
        next_st.rsp.rdata = st.scale_user_units;
        if (param_in.we) begin
          if (wr_ok) begin
            next_st.scale_user_units = param_in.wdata;
          end else begin
            next_st.rsp.err = 1'b1;
          end
        end
      // Offsets past the last line word are unmapped, not aliased
      end else if (addr_off <
                   16'(LINE_COUNT) * ADDR_LINE_FUNC_STEP &&
                   !addr_off[0]) begin
        next_st.rsp.rdata = {16'h0000, st.func[line_sel]};
        if (param_in.we) begin
          if (!power_stage_enabled && param_in.wdata[31:16] == '0 &&
              code_ok(line_sel, param_in.wdata[15:0])) begin
            next_st.func[line_sel] = param_in.wdata[15:0];
          end else begin
            next_st.rsp.err = 1'b1;
          end
        end
      end else if (param_in.addr == ADDR_LINE_LEVELS) begin
        next_st.rsp.rdata = {28'h000_0000, line_free_in};
        next_st.rsp.err = param_in.we;
      end else if (param_in.addr == ADDR_FREE_OUTPUTS) begin
        next_st.rsp.rdata = {28'h000_0000, st.free_out};
        if (param_in.we) begin
          next_st.free_out = param_in.wdata[3:0];
        end
      end else begin
        next_st.rsp.err = 1'b1;
      end
    end

    // Serial restoring divider, one quotient bit per cycle
    case (st.cst)
      CONV_IDLE: begin
        if (conv_req) begin
          next_st.neg = conv_value[31];
          mag_in = conv_value[31] ? 33'(-$signed({conv_value[31],
                                                   conv_value}))
                                  : {1'b0, conv_value};
          if (!conv_to_user) begin
            // User units to increments: x * num * 32768 / den
            // Widen before multiplying so the product is never cut
            next_st.quo = (80'(mag_in) * 80'(st.act_num)) <<
                          INC_PER_REV_SHIFT;
            next_st.dvs = 48'(st.act_den);
          end else begin
            // Increments to user units: x * den / (num * 32768)
            next_st.quo = 80'(mag_in) * 80'(st.act_den);
            next_st.dvs = 48'(st.act_num) << INC_PER_REV_SHIFT;
          end
          next_st.rem = '0;
          next_st.cnt = DIV_STEPS;
          next_st.busy = 1'b1;
          next_st.cst = CONV_RUN;
        end
      end
      CONV_RUN: begin
        trial = {st.rem, st.quo[DIVIDEND_W-1]};
        if (trial >= {1'b0, st.dvs}) begin
          trial = trial - {1'b0, st.dvs};
          next_st.quo = {st.quo[DIVIDEND_W-2:0], 1'b1};
        end else begin
          next_st.quo = {st.quo[DIVIDEND_W-2:0], 1'b0};
        end
        next_st.rem = trial[DIVISOR_W-1:0];
        next_st.cnt = st.cnt - 7'd1;
        if (st.cnt == 7'd1) begin
          next_st.cst = CONV_FINISH;
        end
      end
      CONV_FINISH: begin
        // Results past the signed 32-bit range are clamped, never wrapped
        lim_mag = st.neg ? NEG_MAX_MAG : POS_MAX_MAG;
        if (st.quo > lim_mag) begin
          out_mag = lim_mag;
          next_st.limited = 1'b1;
        end else begin
          out_mag = st.quo;
          next_st.limited = 1'b0;
        end
        next_st.result = st.neg ? 32'(-out_mag) : out_mag[31:0];
        next_st.done = 1'b1;
        next_st.busy = 1'b0;
        next_st.cst = CONV_IDLE;
      end
      default: begin
        next_st.busy = 1'b0;
        next_st.cst = CONV_IDLE;
      end
    endcase

    // Line pins and decoded input functions
    next_st.line_out = line_drives & line_value;
    next_st.line_oe_n = ~line_drives;
    next_st.funcs = '0;
    for (int i = 0; i < LINE_COUNT; i++) begin
      next_st.funcs = next_st.funcs | line_hit[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.scale_revolutions <= RESET_SCALE_REVOLUTIONS;
      st.scale_user_units <= RESET_SCALE_USER_UNITS;
      st.act_num <= RESET_SCALE_REVOLUTIONS;
      st.act_den <= RESET_SCALE_USER_UNITS;
      st.func <= RESET_LINE_FUNCS;
      st.free_out <= RESET_FREE_OUTPUTS;
      st.line_oe_n <= 4'hf;
      st.cst <= CONV_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign param_out = st.rsp;
  assign conv_busy = st.busy;
  assign conv_done = st.done;
  assign conv_result = st.result;
  assign conv_limited = st.limited;
  assign scale_fine = st.fine;
  assign line_out = st.line_out;
  assign line_oe_n = st.line_oe_n;
  assign input_functions = st.funcs;

endmodule

/* bench/scaling_io_chk.sv */
`timescale 1ns/1ps
module scaling_io_chk
  import scaling_io_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_stage_enabled,
  input wire param_req_t param_in,
  input wire param_rsp_t param_out,
  input wire logic conv_req,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic scale_fine
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire wr = param_in.req && param_in.we;
  wire num_wr = wr && param_in.addr == ADDR_SCALE_REVOLUTIONS;
  wire den_wr = wr && param_in.addr == ADDR_SCALE_USER_UNITS;
  wire bad = param_in.wdata == '0 || param_in.wdata[31];
  wire acc = conv_req && !conv_busy && !conv_done;
  wire a2 = param_in.addr == 16'h0724;
  wire a3 = param_in.addr == 16'h0726;
  wire a4 = param_in.addr == 16'h0728;
  AST_ACK_NEXT: assert property (param_in.req |=> param_out.ack)
    else $error("no answer one cycle after request");
  AST_CONV_DONE: assert property (acc |-> ##82 conv_done)
    else $error("conversion not done 82 cycles after start");
  AST_CONV_BUSY: assert property (acc |=> conv_busy [*8])
    else $error("busy not held after conversion start");
  AST_POWER_LOCK: assert property ((num_wr || den_wr) &&
    power_stage_enabled |=> param_out.ack && param_out.err)
    else $error("scale write accepted with power stage on");
  AST_NUM_RANGE: assert property (num_wr && bad |=> param_out.err)
    else $error("numerator out of range accepted");
  AST_DEN_RANGE: assert property (den_wr && bad |=> param_out.err)
    else $error("denominator out of range accepted");
  AST_LIMIT_SWITCH_POSITIVE_LINE: assert property (wr && (a2 || a3 || a4) &&
    param_in.wdata == {16'h0000, FN_IN_LIMIT_POS} |=> param_out.err)
    else $error("positive limit accepted off line one");
  AST_LIMIT_SWITCH_NEGATIVE_LINE: assert property (wr && (a3 || a4 || param_in.addr ==
    ADDR_LINE_FUNC_BASE) && param_in.wdata == {16'h0000, FN_IN_LIMIT_NEG}
    |=> param_out.err)
    else $error("negative limit accepted off line two");
  AST_SCALE_ON_NUM: assert property ($changed(scale_fine) |->
    $past(num_wr))
    else $error("active scale changed without numerator write");
  AST_STATUS_RO: assert property (wr && param_in.addr ==
    ADDR_LINE_LEVELS |=> param_out.err)
    else $error("write to line status accepted");
  cover property (acc);
  cover property (num_wr && !power_stage_enabled);
  cover property (den_wr && power_stage_enabled);
endmodule

bind position_scaling_io_assign scaling_io_chk chk (.sys_clk, .nrst,
  .power_stage_enabled, .param_in, .param_out, .conv_req, .conv_busy,
  .conv_done, .scale_fine);

/* bench/param_master.sv */
`timescale 1ns/1ps
module param_master
  import scaling_io_pkg::*;
(
  input wire logic sys_clk,
  output param_req_t param_in,
  input wire param_rsp_t param_out
);
  initial param_in = '0;
  // Holds no user-unit settings, so a rescale has nothing to touch
  task automatic access(input logic we, input logic [15:0] a,
      input logic [31:0] d, output param_rsp_t rsp);
    @(posedge sys_clk);
    param_in <= '{req: 1'b1, we: we, addr: a, wdata: d};
    @(posedge sys_clk);
    // Released fields flip so stale values cannot pass for fresh ones
    param_in <= '{req: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    #1;
    rsp = param_out;
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import scaling_io_pkg::*;
  typedef struct packed {
    logic we;
    logic [15:0] a;
    logic [31:0] d;
    logic e;
    logic [31:0] r;
  } row_t;
  logic sys_clk, nrst, power_stage_enabled, no_fault, drive_active;
  logic conv_req, conv_to_user, conv_busy, conv_done, conv_limited;
  logic scale_fine;
  logic [31:0] conv_value, conv_result;
  logic [3:0] line_in, line_out, line_oe_n;
  param_req_t param_in;
  param_rsp_t param_out;
  in_funcs_t input_functions;
  int n_mismatch, samples_checked;
  row_t rows [13] = '{
    '{1'b0, 16'h0610, '0, 1'b0, 32'h0000_0001},
    '{1'b0, 16'h060e, '0, 1'b0, 32'h0000_4000},
    '{1'b0, 16'h0722, '0, 1'b0, 32'h0000_0015},
    '{1'b0, 16'h0724, '0, 1'b0, 32'h0000_0016},
    '{1'b0, 16'h0726, '0, 1'b0, 32'h0000_0001},
    '{1'b0, 16'h0728, '0, 1'b0, 32'h0000_0014},
    '{1'b1, 16'h0724, 32'h0000_0015, 1'b1, '0},
    '{1'b1, 16'h0722, 32'h0000_0016, 1'b1, '0},
    '{1'b1, 16'h0730, '0, 1'b1, '0},
    '{1'b0, 16'h0700, '0, 1'b1, '0},
    '{1'b0, 16'h072a, '0, 1'b1, '0},
    '{1'b1, 16'h0610, '0, 1'b1, '0},
    '{1'b1, 16'h060e, 32'h8000_0000, 1'b1, '0}};
  // Free input last so line three ends up free again
  logic [15:0] codes [11] = '{FN_IN_FAULT_RESET, FN_IN_ENABLE, FN_IN_HALT,
    FN_IN_JOG_POS, FN_IN_JOG_NEG, FN_IN_JOG_FAST, FN_IN_REF_SWITCH,
    FN_OUT_FREE, FN_OUT_NO_FAULT, FN_OUT_ACTIVE, FN_IN_FREE};

  position_scaling_io_assign uut (.sys_clk, .nrst, .power_stage_enabled,
    .no_fault, .drive_active, .param_in, .param_out, .conv_req,
    .conv_to_user, .conv_value, .conv_busy, .conv_done, .conv_result,
    .conv_limited, .scale_fine, .line_in, .line_out, .line_oe_n,
    .input_functions);
  param_master master (.sys_clk, .param_in, .param_out);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic we, input logic [15:0] a,
      input logic [31:0] d, input logic e, input logic [31:0] r);
    param_rsp_t rsp;
    master.access(we, a, d, rsp);
    check("ack", 32'h0000_0001, {31'h0, rsp.ack});
    check("err", {31'h0, e}, {31'h0, rsp.err});
    if (!we && !e) begin
      check("rdata", r, rsp.rdata);
    end
  endtask

  task automatic conv(input logic u, input logic [31:0] v,
      input logic [31:0] exp, input logic lim);
    int i;
    @(posedge sys_clk);
    conv_req <= 1'b1;
    conv_to_user <= u;
    conv_value <= v;
    @(posedge sys_clk);
    conv_req <= 1'b0;
    for (i = 0; i < 100 && conv_done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (conv_done !== 1'b1) begin
      n_mismatch++;
      results();
    end
    // Done is launched by the 81st edge after the accept edge
    check("latency", 32'd81, i);
    check("result", exp, conv_result);
    check("limited", {31'h0, lim}, {31'h0, conv_limited});
  endtask

  initial begin
    nrst = 1'b0;
    power_stage_enabled = 1'b0;
    no_fault = 1'b0;
    drive_active = 1'b0;
    conv_req = 1'b0;
    conv_to_user = 1'b0;
    conv_value = '0;
    line_in = 4'h0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[j]) begin
      acc(rows[j].we, rows[j].a, rows[j].d, rows[j].e, rows[j].r);
    end
    foreach (codes[j]) begin
      acc(1'b1, 16'h0726, {16'h0000, codes[j]}, 1'b0, '0);
      acc(1'b0, 16'h0726, '0, 1'b0, {16'h0000, codes[j]});
    end
    conv(1'b0, 32'h0000_0001, 32'h0000_0002, 1'b0);
    acc(1'b1, 16'h060e, 32'h0000_0008, 1'b0, '0);
    conv(1'b0, 32'h0000_0001, 32'h0000_0002, 1'b0);
    acc(1'b1, 16'h0610, 32'h0000_0001, 1'b0, '0);
    conv(1'b0, 32'h0000_0001, 32'h0000_1000, 1'b0);
    conv(1'b1, 32'h0000_1000, 32'h0000_0001, 1'b0);
    conv(1'b0, 32'hffff_ffff, 32'hffff_f000, 1'b0);
    conv(1'b0, 32'h7fff_ffff, 32'h7fff_ffff, 1'b1);
    @(posedge sys_clk);
    power_stage_enabled <= 1'b1;
    acc(1'b1, 16'h0610, 32'h0000_0002, 1'b1, '0);
    acc(1'b1, 16'h060e, 32'h0000_0002, 1'b1, '0);
    acc(1'b0, 16'h060e, '0, 1'b0, 32'h0000_0008);
    conv(1'b0, 32'h0000_0001, 32'h0000_1000, 1'b0);
    @(posedge sys_clk);
    power_stage_enabled <= 1'b0;
    check("fine", '0, {31'h0, scale_fine});
    acc(1'b1, 16'h060e, 32'h7fff_ffff, 1'b0, '0);
    acc(1'b1, 16'h0610, 32'h0000_0001, 1'b0, '0);
    check("fine", 32'h0000_0001, {31'h0, scale_fine});
    @(posedge sys_clk);
    line_in <= 4'hf;
    acc(1'b0, 16'h0730, '0, 1'b0, 32'h0000_0004);
    // Reference on line four, both limits on lines one and two
    check("funcs", 32'h0000_0007, {23'h0, input_functions});
    acc(1'b1, 16'h0726, {16'h0000, FN_OUT_FREE}, 1'b0, '0);
    acc(1'b1, 16'h0732, 32'h0000_0004, 1'b0, '0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("oe_n", 32'h0000_000b, {28'h0, line_oe_n});
    check("out", 32'h0000_0004, {28'h0, line_out});
    // Status sources differ so a wrong mux leg shows up
    @(posedge sys_clk);
    drive_active <= 1'b1;
    acc(1'b1, 16'h0726, {16'h0000, FN_OUT_ACTIVE}, 1'b0, '0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("out", 32'h0000_0004, {28'h0, line_out});
    acc(1'b1, 16'h0726, {16'h0000, FN_OUT_NO_FAULT}, 1'b0, '0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("out", 32'h0000_0000, {28'h0, line_out});
    // Second reset mid-run must bring back the factory values
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check("oe_n", 32'h0000_000f, {28'h0, line_oe_n});
    repeat (3) @(posedge sys_clk);
    acc(1'b0, 16'h0610, '0, 1'b0, 32'h0000_0001);
    acc(1'b0, 16'h060e, '0, 1'b0, 32'h0000_4000);
    acc(1'b0, 16'h0726, '0, 1'b0, 32'h0000_0001);
    results();
  end
endmodule
